// *** hw/cpg_gate.sv ***
// Permission gate, key store and command-slot telegram selection for the config store.
// Contract
// - In gp mode, a non-generic device id picks command from eight slots by rockers and action.
// - A slot holding 0xff suppresses the gp data telegram for that event; ble mode and generic id ignore slots.
// - Primary key is the default for telegram authentication and private addresses.
// - Reading the primary key register returns its contents.
// - Key-selection field in the active radio's security setup picks secondary key.
// - Secondary key is writable but always reads as zero.
// - Tertiary key encrypts commissioning key; write-only, reads as zero.
// - Both masks share one layout: security, gp, ble, system bytes.
// - An option is available to a user only when its mask bit is one.
// - Owner withdraws delegate options by clearing delegate mask bits.
// - Only owner edits delegate mask and owner pin; both edit delegate pin.
// - Security byte: keys bits 0-2, mask bit 4, pins bits 6 and 7.
// - Gp byte: transmit, security, buttons, protocol, unpair at bits 0,1,2,4,5.
// - Ble byte: bits 0 to 5 grant the six ble options.
// - System byte: commission, factory reset, button and radio at bits 0,1,4,5.
// - Reserved bits read zero and are never granted.
// - Factory defaults grant every non-reserved gp, ble and system bit to both.
// - Ungranted option yields permission error coded by kind and user.
`timescale 1ns/100ps
`include "cpg_defs.svh"
module cpg_gate (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 reqValid,
  input  wire cpg_pkg::cpg_req_type req,
  output logic                      reqReady,
  output logic [7:0]                reqStatus,
  input  wire logic                 rdReq,
  input  wire cpg_pkg::cpg_read_type rdSel,
  output logic                      rdValid,
  output logic [127:0]              rdData,
  input  wire logic                 rockerA,
  input  wire logic                 rockerB,
  input  wire logic                 harvestEvent,
  input  wire logic                 harvestPress,
  output cpg_pkg::cpg_tx_type       tx,
  output logic                      bleMode,
  output logic [127:0]              commissionKey
);
  cpg_pkg::cpg_state_type st_reg;
  cpg_pkg::cpg_state_type st_next;
  logic [1:0]  rockerSync;
  logic [31:0] userMask;
  logic        granted;
  logic [4:0]  target;
  logic [7:0]  code;
  logic [2:0]  slotIdx;
  logic [7:0]  slotSel;
  logic [1:0]  keySel;
  logic        genericId;
  // A named copy of the valid mask, because a bare literal cannot be bit-selected.
  localparam logic [31:0] ValidMask = `CPG_VALID_MASK;

  // Rocker pins come from outside the clock domain.
  cpg_sync u_sync (
    .clk     (clk),
    .reset   (reset),
    .pinIn   ({rockerA, rockerB}),
    .pinSync (rockerSync)
  );

  // Permission view of the latched request.
  always_comb begin
    userMask = (st_reg.req.user == cpg_pkg::CPG_OWNER) ? st_reg.ownerMask
                                                       : st_reg.delegateMask;
    case (st_reg.req.kind)
      cpg_pkg::CPG_KIND_COMMISSION: target = `CPG_OPT_SYS_COMMISSION;
      cpg_pkg::CPG_KIND_FACTORY:    target = `CPG_OPT_SYS_FACTORY;
      cpg_pkg::CPG_KIND_UNPAIR:     target = `CPG_OPT_GP_UNPAIR;
      default:                      target = st_reg.req.target;
    endcase
    // Reserved bits fail through the valid mask even if a mask were corrupted.
    granted = userMask[target] & ValidMask[target];
    // Owner-only options are refused to the delegate regardless of its mask.
    if (st_reg.req.user == cpg_pkg::CPG_DELEGATE &&
        (target == `CPG_OPT_DELEGATE_MASK || target == `CPG_OPT_OWNER_PIN)) begin
      granted = 1'b0;
    end
    code = {4'h0, 2'h0, st_reg.req.kind} + 8'h01;
    if (st_reg.req.user == cpg_pkg::CPG_DELEGATE) begin
      code = code | `CPG_ST_DELEGATE;
    end
  end

  // Telegram slot lookup: index is rocker a, rocker b, then press or release.
  always_comb begin
    slotIdx   = {rockerSync[1], rockerSync[0], harvestPress};
    slotSel   = st_reg.slots[{slotIdx, 3'h0} +: 8];
    genericId = (st_reg.gpProtocol[2:0] == `CPG_DEVID_GENERIC);
    keySel    = st_reg.bleMode ? st_reg.bleSecurity[`CPG_KEYSEL_LSB +: 2]
                               : st_reg.gpSecurity[`CPG_KEYSEL_LSB +: 2];
  end

  // Next-state logic for requests, reads and telegrams.
  always_comb begin
    st_next          = st_reg;
    st_next.rdValid  = 1'b0;
    st_next.tx.valid = 1'b0;
    case (st_reg.phase)
      cpg_pkg::CPG_IDLE: begin
        // Kind and user must already stand with the strobe.
        if (reqValid) begin
          st_next.req   = req;
          st_next.phase = cpg_pkg::CPG_CHECK;
        end
      end
      cpg_pkg::CPG_CHECK: begin
        st_next.phase = cpg_pkg::CPG_APPLY;
        if (!st_reg.req.pinOk) begin
          st_next.status = `CPG_ST_PIN_ERR | code;
        end else if (!granted) begin
          st_next.status = `CPG_ST_PERM_ERR | code;
        end else if ((target == `CPG_OPT_GP_SECURITY || target == `CPG_OPT_BLE_SECURITY) &&
                     st_reg.req.data[`CPG_KEYSEL_LSB + 1]) begin
          // Key-selection codes above secondary are undefined.
          st_next.status = `CPG_ST_PARM_ERR | code;
        end else begin
          st_next.status = `CPG_ST_SUCCESS | code;
        end
      end
      cpg_pkg::CPG_APPLY: begin
        st_next.phase = cpg_pkg::CPG_IDLE;
        // Only a success touches stored state; every error leaves it as it was.
        if ((st_reg.status & 8'hf0) == `CPG_ST_SUCCESS) begin
          if (st_reg.req.kind == cpg_pkg::CPG_KIND_FACTORY) begin
            st_next.ownerMask    = `CPG_OWNER_DEFAULT;
            st_next.delegateMask = `CPG_DELEGATE_DEFAULT;
            st_next.gpSecurity   = `CPG_GP_SEC_DEFAULT;
            st_next.bleSecurity  = `CPG_BLE_SEC_DEFAULT;
            st_next.gpProtocol   = `CPG_GP_PROTO_DEFAULT;
            st_next.slots        = `CPG_SLOTS_DEFAULT;
          end else if (st_reg.req.kind == cpg_pkg::CPG_KIND_UPDATE) begin
            if (target == `CPG_OPT_PRIMARY_KEY) begin
              st_next.primaryKey = st_reg.req.data;
            end else if (target == `CPG_OPT_SECONDARY_KEY) begin
              st_next.secondaryKey = st_reg.req.data;
            end else if (target == `CPG_OPT_TERTIARY_KEY) begin
              st_next.tertiaryKey = st_reg.req.data;
            end else if (target == `CPG_OPT_DELEGATE_MASK) begin
              // Cleared bits withdraw options; owner-only bits never reach the delegate.
              st_next.delegateMask = st_reg.req.data[31:0] & `CPG_DELEGATE_LIMIT;
            end else if (target == `CPG_OPT_OWNER_PIN) begin
              st_next.ownerPin = st_reg.req.data[31:0];
            end else if (target == `CPG_OPT_DELEGATE_PIN) begin
              st_next.delegatePin = st_reg.req.data[31:0];
            end else if (target == `CPG_OPT_GP_SECURITY) begin
              st_next.gpSecurity = st_reg.req.data[7:0];
            end else if (target == `CPG_OPT_BLE_SECURITY) begin
              st_next.bleSecurity = st_reg.req.data[7:0];
            end else if (target == `CPG_OPT_GP_PROTOCOL) begin
              st_next.gpProtocol = st_reg.req.data[7:0];
            end else if (target == `CPG_OPT_GP_BUTTON_MAP) begin
              st_next.slots = st_reg.req.data[63:0];
            end else if (target == `CPG_OPT_SYS_RADIO) begin
              st_next.bleMode = st_reg.req.data[`CPG_RADIO_BLE_BIT];
            end
          end
        end
      end
      default: begin
        st_next.phase = cpg_pkg::CPG_IDLE;
      end
    endcase

    // Register reads; the secondary and tertiary keys always read as zero.
    if (rdReq) begin
      st_next.rdValid = 1'b1;
      if (rdSel == cpg_pkg::CPG_RD_PRIMARY) begin
        st_next.rdData = st_reg.primaryKey;
      end else if (rdSel == cpg_pkg::CPG_RD_OWNER) begin
        st_next.rdData = {96'h0, st_reg.ownerMask & `CPG_VALID_MASK};
      end else if (rdSel == cpg_pkg::CPG_RD_DELEGATE) begin
        st_next.rdData = {96'h0, st_reg.delegateMask & `CPG_VALID_MASK};
      end else if (rdSel == cpg_pkg::CPG_RD_STATUS) begin
        st_next.rdData = {120'h0, st_reg.status};
      end else begin
        st_next.rdData = 128'h0;
      end
    end

    // Telegram selection on each harvester action.
    if (harvestEvent) begin
      st_next.tx.key = (keySel == `CPG_KEYSEL_SECONDARY) ? st_reg.secondaryKey
                                                         : st_reg.primaryKey;
      if (st_reg.bleMode || genericId) begin
        st_next.tx.valid   = 1'b1;
        st_next.tx.generic = 1'b1;
        st_next.tx.command = {5'h00, slotIdx};
      end else if (slotSel != `CPG_SLOT_MUTE) begin
        st_next.tx.valid   = 1'b1;
        st_next.tx.generic = 1'b0;
        st_next.tx.command = slotSel;
      end
    end
  end

  // State register; reset loads factory defaults.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg              <= '0;
      st_reg.phase        <= cpg_pkg::CPG_IDLE;
      st_reg.ownerMask    <= `CPG_OWNER_DEFAULT;
      st_reg.delegateMask <= `CPG_DELEGATE_DEFAULT;
      st_reg.gpSecurity   <= `CPG_GP_SEC_DEFAULT;
      st_reg.bleSecurity  <= `CPG_BLE_SEC_DEFAULT;
      st_reg.gpProtocol   <= `CPG_GP_PROTO_DEFAULT;
      st_reg.slots        <= `CPG_SLOTS_DEFAULT;
    end else begin
      st_reg <= st_next;
    end
  end

  // Idle is one-hot bit 0, so ready comes straight from its flop with no decode.
  assign reqReady      = st_reg.phase[0];
  assign reqStatus     = st_reg.status;
  assign rdValid       = st_reg.rdValid;
  assign rdData        = st_reg.rdData;
  assign tx            = st_reg.tx;
  assign bleMode       = st_reg.bleMode;
  assign commissionKey = st_reg.tertiaryKey;

  // Checks on the gate's own behaviour.
  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    ((st_reg.ownerMask | st_reg.delegateMask) & ~`CPG_VALID_MASK) == 32'h0)
    else $error("reserved permission bit set");

  a_delegate_limit: assert property (@(posedge clk) disable iff (reset)
    (st_reg.delegateMask & ~`CPG_DELEGATE_LIMIT) == 32'h0)
    else $error("delegate holds an owner-only option");

  a_muted_slot: assert property (@(posedge clk) disable iff (reset)
    harvestEvent && !st_reg.bleMode && !genericId && slotSel == `CPG_SLOT_MUTE
    |=> !tx.valid)
    else $error("telegram sent from a muted slot");

  a_slot_pick: assert property (@(posedge clk) disable iff (reset)
    harvestEvent && !st_reg.bleMode && !genericId && slotSel != `CPG_SLOT_MUTE
    |=> tx.valid && !tx.generic && tx.command == $past(slotSel))
    else $error("wrong command slot sent");

  a_key_read: assert property (@(posedge clk) disable iff (reset)
    rdReq && rdSel == cpg_pkg::CPG_RD_PRIMARY |=> rdValid && rdData == $past(st_reg.primaryKey))
    else $error("primary key read mismatch");

  a_secret_hidden: assert property (@(posedge clk) disable iff (reset)
    rdReq && (rdSel == cpg_pkg::CPG_RD_SECONDARY || rdSel == cpg_pkg::CPG_RD_TERTIARY)
    |=> rdData == 128'h0)
    else $error("hidden key exposed");

  a_reject_hold: assert property (@(posedge clk) disable iff (reset)
    st_reg.phase == cpg_pkg::CPG_APPLY && st_reg.status[7:4] != 4'h3
    |=> $stable(st_reg.ownerMask) && $stable(st_reg.delegateMask) &&
        $stable(st_reg.primaryKey) && $stable(st_reg.ownerPin) && $stable(st_reg.slots))
    else $error("rejected request changed state");

  a_perm_error: assert property (@(posedge clk) disable iff (reset)
    reqReady && reqValid && req.pinOk && req.user == cpg_pkg::CPG_DELEGATE &&
    req.kind == cpg_pkg::CPG_KIND_UPDATE && req.target == `CPG_OPT_OWNER_PIN
    |-> ##2 reqStatus == 8'h99)
    else $error("missing permission error");

  a_key_choice: assert property (@(posedge clk) disable iff (reset)
    harvestEvent && keySel == `CPG_KEYSEL_SECONDARY
    |=> !tx.valid || tx.key == $past(st_reg.secondaryKey))
    else $error("secondary key not used");

  a_perm_code: assert property (@(posedge clk) disable iff (reset)
    st_reg.phase == cpg_pkg::CPG_CHECK && st_reg.req.pinOk && !granted
    |=> reqStatus == {4'h9, st_reg.req.user, 3'(st_reg.req.kind) + 3'h1})
    else $error("permission error code wrong");

  a_factory_load: assert property (@(posedge clk) disable iff (reset)
    st_reg.phase == cpg_pkg::CPG_APPLY && st_reg.status[7:4] == 4'h3 &&
    st_reg.req.kind == cpg_pkg::CPG_KIND_FACTORY
    |=> st_reg.ownerMask == `CPG_OWNER_DEFAULT && st_reg.delegateMask == `CPG_DELEGATE_DEFAULT)
    else $error("factory defaults not restored");

  a_owner_fixed: assert property (@(posedge clk) disable iff (reset)
    !(st_reg.phase == cpg_pkg::CPG_APPLY && st_reg.req.kind == cpg_pkg::CPG_KIND_FACTORY)
    |=> $stable(st_reg.ownerMask))
    else $error("owner mask changed outside a factory reset");

  a_delegate_edit: assert property (@(posedge clk) disable iff (reset)
    st_reg.phase == cpg_pkg::CPG_APPLY && st_reg.req.user == cpg_pkg::CPG_DELEGATE &&
    st_reg.req.kind == cpg_pkg::CPG_KIND_UPDATE
    |=> $stable(st_reg.delegateMask) && $stable(st_reg.ownerPin))
    else $error("delegate changed an owner-only setting");

  a_reserved_deny: assert property (@(posedge clk) disable iff (reset)
    st_reg.phase == cpg_pkg::CPG_CHECK && st_reg.req.kind == cpg_pkg::CPG_KIND_UPDATE &&
    st_reg.req.target[2:0] == 3'h7 && st_reg.req.target[4:3] != 2'h0
    |=> reqStatus[7:4] != 4'h3)
    else $error("reserved option granted");

  a_generic_pick: assert property (@(posedge clk) disable iff (reset)
    harvestEvent && (st_reg.bleMode || genericId)
    |=> tx.valid && tx.generic && tx.command == {5'h00, $past(slotIdx)})
    else $error("generic telegram wrong");

  a_default_key: assert property (@(posedge clk) disable iff (reset)
    harvestEvent && keySel == `CPG_KEYSEL_PRIMARY
    |=> tx.key == $past(st_reg.primaryKey))
    else $error("primary key not used by default");
endmodule : cpg_gate

// *** include/cpg_defs.svh ***
// Constants for the configuration permission gate: option bits, defaults, codes.
`ifndef CPG_DEFS_SVH
`define CPG_DEFS_SVH

// Option bit index into a 32-bit permission mask: byte 0 security, 1 gp, 2 ble, 3 system.
`define CPG_OPT_PRIMARY_KEY    5'h00
`define CPG_OPT_SECONDARY_KEY  5'h01
`define CPG_OPT_TERTIARY_KEY   5'h02
`define CPG_OPT_DELEGATE_MASK  5'h04
`define CPG_OPT_OWNER_PIN      5'h06
`define CPG_OPT_DELEGATE_PIN   5'h07
`define CPG_OPT_GP_SECURITY    5'h09
`define CPG_OPT_GP_BUTTON_MAP  5'h0a
`define CPG_OPT_GP_PROTOCOL    5'h0c
`define CPG_OPT_GP_UNPAIR      5'h0d
`define CPG_OPT_BLE_SECURITY   5'h11
`define CPG_OPT_SYS_COMMISSION 5'h18
`define CPG_OPT_SYS_FACTORY    5'h19
`define CPG_OPT_SYS_RADIO      5'h1d

// Mask layout and reset values.
`define CPG_VALID_MASK       32'h333f37d7
`define CPG_OWNER_DEFAULT    32'h333f37d7
`define CPG_DELEGATE_DEFAULT 32'h333f3787
`define CPG_DELEGATE_LIMIT   32'h333f3787

// Setup register fields and defaults.
`define CPG_KEYSEL_LSB       2
`define CPG_KEYSEL_PRIMARY   2'h0
`define CPG_KEYSEL_SECONDARY 2'h1
`define CPG_GP_SEC_DEFAULT   8'h00
`define CPG_BLE_SEC_DEFAULT  8'h00
`define CPG_GP_PROTO_DEFAULT 8'h07
`define CPG_DEVID_GENERIC    3'h7
`define CPG_SLOT_MUTE        8'hff
`define CPG_SLOTS_DEFAULT    64'hffffffffffffffff
`define CPG_RADIO_BLE_BIT    0

// Request status codes: outcome in the high nibble, user and kind in the low one.
`define CPG_ST_NONE     8'h00
`define CPG_ST_SUCCESS  8'h30
`define CPG_ST_PIN_ERR  8'h70
`define CPG_ST_PERM_ERR 8'h90
`define CPG_ST_PARM_ERR 8'hb0
`define CPG_ST_DELEGATE 8'h08

`endif

// *** include/cpg_pkg.sv ***
// Types shared by the configuration permission gate modules.
package cpg_pkg;

  typedef enum logic [0:0] {
    CPG_OWNER    = 1'h0,
    CPG_DELEGATE = 1'h1
  } cpg_user_type;

  typedef enum logic [1:0] {
    CPG_KIND_UPDATE     = 2'h0,
    CPG_KIND_COMMISSION = 2'h1,
    CPG_KIND_FACTORY    = 2'h2,
    CPG_KIND_UNPAIR     = 2'h3
  } cpg_kind_type;

  typedef enum logic [2:0] {
    CPG_IDLE  = 3'h1,
    CPG_CHECK = 3'h2,
    CPG_APPLY = 3'h4
  } cpg_phase_type;

  typedef enum logic [2:0] {
    CPG_RD_PRIMARY   = 3'h0,
    CPG_RD_SECONDARY = 3'h1,
    CPG_RD_TERTIARY  = 3'h2,
    CPG_RD_OWNER     = 3'h3,
    CPG_RD_DELEGATE  = 3'h4,
    CPG_RD_STATUS    = 3'h5
  } cpg_read_type;

  typedef struct packed {
    cpg_user_type user;
    cpg_kind_type kind;
    logic [4:0]   target;
    logic         pinOk;
    logic [127:0] data;
  } cpg_req_type;

  typedef struct packed {
    logic         valid;
    logic         generic;
    logic [7:0]   command;
    logic [127:0] key;
  } cpg_tx_type;

  typedef struct packed {
    cpg_phase_type phase;
    cpg_req_type   req;
    logic [7:0]    status;
    logic [31:0]   ownerMask;
    logic [31:0]   delegateMask;
    logic [127:0]  primaryKey;
    logic [127:0]  secondaryKey;
    logic [127:0]  tertiaryKey;
    logic [31:0]   ownerPin;
    logic [31:0]   delegatePin;
    logic [7:0]    gpSecurity;
    logic [7:0]    bleSecurity;
    logic [7:0]    gpProtocol;
    logic [63:0]   slots;
    logic          bleMode;
    cpg_tx_type    tx;
    logic          rdValid;
    logic [127:0]  rdData;
  } cpg_state_type;

  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } cpg_sync_state_type;

endpackage : cpg_pkg

// *** hw/cpg_sync.sv ***
// Two-stage synchroniser for the two rocker pins.
`timescale 1ns/100ps
module cpg_sync (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] pinIn,
  output logic      [1:0] pinSync
);
  cpg_pkg::cpg_sync_state_type st_reg;
  cpg_pkg::cpg_sync_state_type st_next;

  // The first stage feeds only the second one, to let metastability settle.
  always_comb begin
    st_next        = st_reg;
    st_next.first  = pinIn;
    st_next.second = st_reg.first;
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinSync = st_reg.second;
endmodule : cpg_sync

// *** testbench/cpg_reader.sv ***
// Behavioural configuring reader that issues gate requests and register reads.
`timescale 1ns/100ps
module cpg_reader (
  input  wire logic                   clk,
  output logic                        reqValid,
  output cpg_pkg::cpg_req_type        req,
  input  wire logic                   reqReady,
  input  wire logic [7:0]             reqStatus,
  output logic                        rdReq,
  output cpg_pkg::cpg_read_type       rdSel,
  input  wire logic                   rdValid,
  input  wire logic [127:0]           rdData
);
  // The reader starts idle with no strobe raised.
  initial begin
    reqValid = 1'b0;
    req = '0;
    rdReq = 1'b0;
    rdSel = cpg_pkg::CPG_RD_STATUS;
  end

  // One request; the data is inverted after the take so a stale value is never relied on.
  task automatic send(input cpg_pkg::cpg_req_type r, output logic [7:0] status);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= r;
    @(posedge clk);
    reqValid <= 1'b0;
    req.data <= ~r.data;
    #1;
    for (int i = 0; i < 8 && reqReady !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    status = reqStatus;
  endtask : send

  // One register read; a missing valid pulse yields unknown data.
  task automatic fetch(input cpg_pkg::cpg_read_type s, output logic [127:0] d);
    @(posedge clk);
    rdReq <= 1'b1;
    rdSel <= s;
    @(posedge clk);
    rdReq <= 1'b0;
    rdSel <= cpg_pkg::cpg_read_type'(~s);
    #1;
    d = (rdValid === 1'b1) ? rdData : {128{1'bx}};
  endtask : fetch
endmodule : cpg_reader

// *** testbench/cpg_gate_tb.sv ***
// Self-checking bench for the configuration permission gate.
`timescale 1ns/100ps
`include "cpg_defs.svh"
module cpg_gate_tb;
  logic                    clk;
  logic                    reset;
  logic                    reqValid;
  cpg_pkg::cpg_req_type    req;
  logic                    reqReady;
  logic [7:0]              reqStatus;
  logic                    rdReq;
  cpg_pkg::cpg_read_type   rdSel;
  logic                    rdValid;
  logic [127:0]            rdData;
  logic                    rockerA;
  logic                    rockerB;
  logic                    harvestEvent;
  logic                    harvestPress;
  cpg_pkg::cpg_tx_type     tx;
  logic                    bleMode;
  logic [127:0]            commissionKey;
  int                      errTotal;
  int                      nTests;
  logic [127:0]            got;
  cpg_pkg::cpg_tx_type     seen;
  localparam logic [127:0] keyA = {4{32'h1a2b3c4d}};
  localparam logic [127:0] keyB = {4{32'h5e6f7081}};
  localparam logic [127:0] keyC = {4{32'h92a3b4c5}};

  cpg_gate cpg_gate_inst (.clk(clk), .reset(reset), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .reqStatus(reqStatus), .rdReq(rdReq), .rdSel(rdSel),
    .rdValid(rdValid), .rdData(rdData), .rockerA(rockerA), .rockerB(rockerB),
    .harvestEvent(harvestEvent), .harvestPress(harvestPress), .tx(tx),
    .bleMode(bleMode), .commissionKey(commissionKey));

  cpg_reader cpg_reader_inst (.clk(clk), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .reqStatus(reqStatus), .rdReq(rdReq), .rdSel(rdSel),
    .rdValid(rdValid), .rdData(rdData));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic closeOut();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : closeOut

  task automatic chk(input string what, input logic [137:0] exp, input logic [137:0] val);
    nTests++;
    if (val !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, val);
    end
  endtask : chk

  // Status code: outcome base, kind plus one, and eight more for the delegate.
  function automatic logic [7:0] code(input logic [7:0] b, input logic u, input logic [1:0] k);
    return b | {4'h0, u, 3'h0} | ({6'h0, k} + 8'h01);
  endfunction : code

  task automatic rq(input logic u, input logic [1:0] k, input logic [4:0] t, input logic p,
                    input logic [127:0] d, input logic [7:0] exp);
    logic [7:0] s;
    cpg_reader_inst.send({cpg_pkg::cpg_user_type'(u), cpg_pkg::cpg_kind_type'(k), t, p, d}, s);
    chk("status", exp, s);
  endtask : rq

  task automatic rd(input logic [2:0] sel, input logic [127:0] exp);
    cpg_reader_inst.fetch(cpg_pkg::cpg_read_type'(sel), got);
    chk("read", exp, got);
  endtask : rd

  // Rockers settle through the synchroniser before the harvester action is pulsed.
  task automatic fire(input logic a, input logic b, input logic press);
    @(posedge clk);
    rockerA <= a;
    rockerB <= b;
    harvestPress <= press;
    repeat (3) @(posedge clk);
    harvestEvent <= 1'b1;
    @(posedge clk);
    harvestEvent <= 1'b0;
    #1;
    seen = tx;
  endtask : fire

  // Watchdog sized well beyond the roughly 160 cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    closeOut();
  end

  // Main sequence of requests, reads and harvester events.
  initial begin
    errTotal = 0;
    nTests = 0;
    reset = 1'b1;
    rockerA = 1'b0;
    rockerB = 1'b0;
    harvestEvent = 1'b0;
    harvestPress = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("ready", 1'b1, reqReady);
    chk("idle status", `CPG_ST_NONE, reqStatus);
    rd(3, 128'h333f37d7);
    rd(4, 128'h333f3787);
    rq(0, 0, 5'h00, 1, keyA, 8'h31);
    rd(0, keyA);
    rq(0, 0, 5'h01, 1, keyB, 8'h31);
    rd(1, 128'h0);
    rq(1, 0, 5'h02, 1, keyC, 8'h39);
    rd(2, 128'h0);
    chk("commission key", keyC, commissionKey);
    rq(0, 0, 5'h00, 0, keyB, 8'h71);
    rq(1, 0, 5'h06, 1, 128'h1, 8'h99);
    rq(1, 0, 5'h04, 1, 128'h0, 8'h99);
    rq(1, 0, 5'h07, 1, 128'h2, 8'h39);
    rq(0, 0, 5'h03, 1, 128'h0, 8'h91);
    rd(5, 128'h91);
    rq(0, 0, 5'h04, 1, 128'h333f3786, 8'h31);
    rd(4, 128'h333f3786);
    rq(1, 0, 5'h00, 1, keyB, 8'h99);
    rd(0, keyA);
    // Commission, factory reset and unpair for both users; factory restores the masks.
    for (int u = 0; u < 2; u++) begin
      for (int k = 1; k < 4; k++) begin
        rq(u[0], k[1:0], (k == 1) ? 5'h18 : (k == 2) ? 5'h19 : 5'h0d, 1'b1, 128'h0,
           code(`CPG_ST_SUCCESS, u[0], k[1:0]));
      end
    end
    rd(4, 128'h333f3787);
    rq(0, 0, 5'h04, 1, 128'hfffffff6, 8'h31);
    rd(4, 128'h333f3786);
    fire(1, 0, 1);
    chk("generic tx", {1'b1, 1'b1, 8'h05, keyA}, seen);
    rq(0, 0, 5'h0c, 1, 128'h0, 8'h31);
    fire(1, 0, 1);
    chk("muted default slot", 1'b0, seen.valid);
    rq(0, 0, 5'h0a, 1, 128'hffff42ffffffffff, 8'h31);
    fire(1, 0, 1);
    chk("slot tx", {1'b1, 1'b0, 8'h42, keyA}, seen);
    fire(1, 0, 0);
    chk("muted release", 1'b0, seen.valid);
    rq(0, 0, 5'h09, 1, 128'h04, 8'h31);
    fire(1, 0, 1);
    chk("secondary key tx", {1'b1, 1'b0, 8'h42, keyB}, seen);
    rq(0, 0, 5'h09, 1, 128'h0c, 8'hb1);
    fire(1, 0, 1);
    chk("key kept", {1'b1, 1'b0, 8'h42, keyB}, seen);
    // Reserved gp bit 7 is refused; then the ble radio takes its key from its own setup.
    rq(1, 0, 5'h0f, 1, 128'h0, 8'h99);
    rq(0, 0, 5'h1d, 1, 128'h1, 8'h31);
    chk("ble mode", 1'b1, bleMode);
    fire(1, 0, 1);
    chk("ble primary tx", {1'b1, 1'b1, 8'h05, keyA}, seen);
    rq(1, 0, 5'h11, 1, 128'h04, 8'h39);
    fire(1, 0, 0);
    chk("ble secondary tx", {1'b1, 1'b1, 8'h04, keyB}, seen);
    closeOut();
  end
endmodule : cpg_gate_tb
